/* File: logic/mode_cmd_pkg.sv */
// shared constants and types for the mode command handler
package mode_cmd_pkg;
	// register offsets (word index on the host port)
	localparam logic [15:0] PEND_OFS = 16'h0009;
	localparam logic [15:0] IEN_OFS = 16'h0012;
	localparam logic [15:0] CFG_OFS = 16'h0017;
	localparam logic [15:0] BITW_A_OFS = 16'h001E;
	localparam logic [15:0] BITW_B_OFS = 16'h001F;
	// field positions
	localparam int ACC_IRQ_BIT = 0;
	localparam int SMS_BIT = 1;
	localparam int UCI_BIT = 2;
	localparam int ALT_BIT = 3;
	localparam int DESC_IRQ_BIT = 15;
	localparam int ILOG_ACC_BIT = 0;
	// reset values
	localparam logic [15:0] PEND_RST = 16'h0000;
	localparam logic [15:0] IEN_RST = 16'h0000;
	localparam logic [15:0] CFG_RST = 16'h0000;
	localparam logic [15:0] BITW_RST = 16'h0000;
	// descriptor table placement for mode commands
	localparam logic [15:0] DESC_RX_BASE = 16'h0400;
	localparam logic [15:0] DESC_TX_BASE = 16'h0480;
	localparam int DESC_WORDS_LOG2 = 2;
	localparam logic [1:0] DESC_DATA_WORD = 2'h3;
	// log of decision to completion, in clock cycles
	localparam int LOG_CYCLES = 2;

	typedef enum logic [1:0] {
		RESP_NONE,
		RESP_STATUS,
		RESP_STATUS_DATA,
		RESP_RX_DATA
	} resp_t;

	typedef struct packed {
		logic tr;
		logic [4:0] subaddr;
		logic [4:0] code;
		logic bcast;
	} cmd_t;

	typedef struct packed {
		logic valid;
		logic illegal;
		logic bcastOk;
		resp_t resp;
		logic dataFromBitReg;
		logic dataFromLastCmd;
		logic dataInDesc;
		logic [15:0] descAddr;
	} decision_t;
endpackage

/* File: logic/rt_mode_command_handler.sv */
// mode command decoder, response selector and access interrupt logger
// Notes on behaviour
// - descriptor control top bit (bit 15) steers interrupts
// - broadcast-transmit allowed only for codes 0-15
// - flagged access sets pending bit, drives interrupt
// - log entry written before interrupt asserts
// - logged info word carries access flag
// - logged address is descriptor control word address
// - codes 0-15 answer with status only
// - receive codes 16-31 take one data word
// - transmit codes 16-31 send status plus data
// - without simple storage use descriptor buffer
// - with simple storage data sits in descriptor
// - decode transmit codes 0 to 8
// - decode defined data-word mode codes
// - broadcast accepted only for listed codes
// - undefined codes ignored when flagged invalid
// - otherwise undefined codes follow illegalization bit
// - legal undefined codes answer in form
// - illegal: message error, status without data
// - reserved codes follow illegalization bit only
// - undefined-invalid option clear after reset
// - self-test word from one of two registers
// - last command word generated from history
`timescale 1ns/100ps
module rt_mode_command_handler (
	input wire logic clk,
	input wire logic nrst,
	// command word side from the bus decoder
	input wire logic cmdStrobe,
	input wire mode_cmd_pkg::cmd_t cmdIn,
	input wire logic [15:0] cmdWord,
	input wire logic [15:0] descControl,
	input wire logic illegalBit,
	input wire logic rxDataStrobe,
	input wire logic [15:0] rxData,
	// host register port
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [15:0] regAddr,
	input wire logic [15:0] regWdata,
	output logic [15:0] regRdata,
	// decision and reply outputs
	output logic isMode,
	output mode_cmd_pkg::decision_t decision,
	output logic decisionValid,
	output logic [15:0] txData,
	output logic messageErrorFlag,
	// received mode data word write
	output logic storeStrobe,
	output logic [15:0] storeAddr,
	output logic [15:0] storeData,
	// interrupt log entry and pin
	output logic logStrobe,
	output logic [15:0] interruptInfoWord,
	output logic [15:0] interruptAddressWord,
	output logic interruptOutN
);
	// synchronised reset, host registers and internal state
	logic rstSync1, rstSync2;
	logic [15:0] pendingInterrupts_r, interruptEnables_r;
	logic [15:0] terminalConfiguration_r;
	logic [15:0] bitWordA_r, bitWordB_r, lastCmd_r;
	logic [1:0] logCnt_r;
	logic logPend_r, rxPend_r;
	logic [15:0] rxAddr_r;
	mode_cmd_pkg::decision_t dec_nxt;
	logic irqHit;

	// reset release through two flops
	// asserts at once, releases on clock edges only
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rstSync1 <= 1'b0;
			rstSync2 <= 1'b0;
		end else begin
			rstSync1 <= 1'b1;
			rstSync2 <= rstSync1;
		end
	end

	// mode command test on subaddress
	function automatic logic modeSub(input logic [4:0] sa);
		return (sa == 5'h00) || (sa == 5'h1F);
	endfunction

	// undefined code classes
	function automatic logic undefinedCode(input logic tr,
		input logic [4:0] c);
		// receive 0-16, 18, 19; transmit 17, 20, 21
		if (!tr)
			return (c <= 5'h0F) || c == 5'h10 || c == 5'h12
				|| c == 5'h13;
		return c == 5'h11 || c == 5'h14 || c == 5'h15;
	endfunction

	// broadcast acceptance table
	function automatic logic bcastAllowed(input logic tr,
		input logic [4:0] c);
		if (tr)
			return (c == 5'h01) || (c >= 5'h03 && c <= 5'h0F);
		return c == 5'h11 || c == 5'h14 || c == 5'h15
			|| c >= 5'h16;
	endfunction

	// descriptor control word address from code and direction
	function automatic logic [15:0] descAddrOf(input logic tr,
		input logic [4:0] c);
		logic [15:0] base;
		// four words per code, control word first
		base = tr ? mode_cmd_pkg::DESC_TX_BASE
			: mode_cmd_pkg::DESC_RX_BASE;
		return base + {9'h000, c, 2'b00};
	endfunction

	// combinational decision for the incoming command
	always_comb begin
		logic undef;
		logic dataWord;
		undef = undefinedCode(cmdIn.tr, cmdIn.code);
		dataWord = cmdIn.code[4];
		dec_nxt = '0;
		dec_nxt.resp = mode_cmd_pkg::RESP_NONE;
		// table lookups for this code and direction
		dec_nxt.descAddr = descAddrOf(cmdIn.tr, cmdIn.code);
		dec_nxt.bcastOk = bcastAllowed(cmdIn.tr, cmdIn.code);
		// invalid undefined codes get no recognition at all
		dec_nxt.valid = !(undef
			&& terminalConfiguration_r[mode_cmd_pkg::UCI_BIT]);
		// legality purely from table bit
		dec_nxt.illegal = dec_nxt.valid && illegalBit;
		// reply form: recognition, broadcast, legality, data class
		if (!dec_nxt.valid || (cmdIn.bcast && !dec_nxt.bcastOk))
			dec_nxt.resp = mode_cmd_pkg::RESP_NONE;
		else if (dec_nxt.illegal)
			dec_nxt.resp = cmdIn.bcast ? mode_cmd_pkg::RESP_NONE
				: mode_cmd_pkg::RESP_STATUS;
		else if (!dataWord)
			dec_nxt.resp = cmdIn.bcast ? mode_cmd_pkg::RESP_NONE
				: mode_cmd_pkg::RESP_STATUS;
		else if (!cmdIn.tr)
			dec_nxt.resp = mode_cmd_pkg::RESP_RX_DATA;
		else
			dec_nxt.resp = mode_cmd_pkg::RESP_STATUS_DATA;
		// special transmit sources
		dec_nxt.dataFromLastCmd = cmdIn.tr && cmdIn.code == 5'h12;
		dec_nxt.dataFromBitReg = cmdIn.tr && cmdIn.code == 5'h13;
		dec_nxt.dataInDesc =
			terminalConfiguration_r[mode_cmd_pkg::SMS_BIT];
	end

	// decision register and transmit data selection
	always_ff @(posedge clk or negedge rstSync2) begin
		if (!rstSync2) begin
			decision <= '0;
			decisionValid <= 1'b0;
			isMode <= 1'b0;
			txData <= 16'h0000;
			messageErrorFlag <= 1'b0;
		end else begin
			// one-cycle pulse per mode command
			decisionValid <= cmdStrobe && modeSub(cmdIn.subaddr);
			if (cmdStrobe) begin
				isMode <= modeSub(cmdIn.subaddr);
				decision <= dec_nxt;
				if (modeSub(cmdIn.subaddr) && dec_nxt.valid)
					messageErrorFlag <= dec_nxt.illegal;
				// reply word source chosen with the command
				if (dec_nxt.dataFromBitReg)
					txData <= terminalConfiguration_r[
						mode_cmd_pkg::ALT_BIT] ? bitWordB_r
						: bitWordA_r;
				else if (dec_nxt.dataFromLastCmd)
					txData <= lastCmd_r;
				else
					txData <= 16'h0000;
			end
		end
	end

	// last valid command kept for the transmit-last-command reply
	always_ff @(posedge clk or negedge rstSync2) begin
		if (!rstSync2)
			lastCmd_r <= 16'h0000;
		// the last-command request itself is not recorded
		else if (cmdStrobe && !(modeSub(cmdIn.subaddr)
			&& cmdIn.tr && cmdIn.code == 5'h12) && dec_nxt.valid)
			lastCmd_r <= cmdWord;
	end

	// received mode data word storage
	always_ff @(posedge clk or negedge rstSync2) begin
		if (!rstSync2) begin
			rxPend_r <= 1'b0;
			rxAddr_r <= 16'h0000;
			storeStrobe <= 1'b0;
			storeAddr <= 16'h0000;
			storeData <= 16'h0000;
		end else begin
			storeStrobe <= 1'b0;
			if (cmdStrobe) begin
				// arm for one data word after a receive command
				rxPend_r <= modeSub(cmdIn.subaddr)
					&& dec_nxt.resp == mode_cmd_pkg::RESP_RX_DATA;
				// simple storage: data word inside the descriptor entry
				rxAddr_r <= dec_nxt.dataInDesc
					? dec_nxt.descAddr + {14'h0000,
						mode_cmd_pkg::DESC_DATA_WORD}
					: descControl;
			end else if (rxPend_r && rxDataStrobe) begin
				// write the word, later words are dropped
				rxPend_r <= 1'b0; // exactly one word
				storeStrobe <= 1'b1;
				storeAddr <= rxAddr_r;
				storeData <= rxData;
			end
		end
	end

	// access interrupt trigger; no broadcast transmit of data codes
	assign irqHit = cmdStrobe && modeSub(cmdIn.subaddr) && dec_nxt.valid
		&& descControl[mode_cmd_pkg::DESC_IRQ_BIT]
		&& interruptEnables_r[mode_cmd_pkg::ACC_IRQ_BIT]
		&& !(cmdIn.bcast && cmdIn.tr && cmdIn.code[4]);

	// access interrupt: log first, then pending bit and pin
	always_ff @(posedge clk or negedge rstSync2) begin
		if (!rstSync2) begin
			logPend_r <= 1'b0;
			logCnt_r <= 2'h0;
			logStrobe <= 1'b0;
			interruptInfoWord <= 16'h0000;
			interruptAddressWord <= 16'h0000;
		end else begin
			logStrobe <= 1'b0;
			if (irqHit) begin
				logStrobe <= 1'b1;
				interruptInfoWord <= 16'h0001
					<< mode_cmd_pkg::ILOG_ACC_BIT;
				interruptAddressWord <= dec_nxt.descAddr;
				logPend_r <= 1'b1;
				logCnt_r <= 2'(mode_cmd_pkg::LOG_CYCLES - 1);
			end else if (logPend_r) begin
				// count down, then hand over to the pending bit
				if (logCnt_r == 2'h0)
					logPend_r <= 1'b0;
				else
					logCnt_r <= logCnt_r - 2'h1;
			end
		end
	end

	// host registers; pending bit set wins over write-one clear
	always_ff @(posedge clk or negedge rstSync2) begin
		if (!rstSync2) begin
			pendingInterrupts_r <= mode_cmd_pkg::PEND_RST;
			interruptEnables_r <= mode_cmd_pkg::IEN_RST;
			terminalConfiguration_r <= mode_cmd_pkg::CFG_RST;
			bitWordA_r <= mode_cmd_pkg::BITW_RST;
			bitWordB_r <= mode_cmd_pkg::BITW_RST;
			interruptOutN <= 1'b1;
		end else begin
			// host writes; pending bits clear on one
			if (regWrite) begin
				unique case (regAddr)
					mode_cmd_pkg::PEND_OFS:
						pendingInterrupts_r <= pendingInterrupts_r
							& ~regWdata;
					mode_cmd_pkg::IEN_OFS: interruptEnables_r <= regWdata;
					mode_cmd_pkg::CFG_OFS:
						terminalConfiguration_r <= regWdata;
					mode_cmd_pkg::BITW_A_OFS: bitWordA_r <= regWdata;
					mode_cmd_pkg::BITW_B_OFS: bitWordB_r <= regWdata;
					default: ;
				endcase
			end
			// set after the write, so a same-cycle set wins
			if (logPend_r && logCnt_r == 2'h0)
				pendingInterrupts_r[mode_cmd_pkg::ACC_IRQ_BIT]
					<= 1'b1;
			// pin follows pending bits one clock later
			interruptOutN <= !(|pendingInterrupts_r);
		end
	end

	// register read port
	always_ff @(posedge clk or negedge rstSync2) begin
		if (!rstSync2)
			regRdata <= 16'h0000;
		else if (regRead) begin
			unique case (regAddr)
				mode_cmd_pkg::PEND_OFS: regRdata <= pendingInterrupts_r;
				mode_cmd_pkg::IEN_OFS: regRdata <= interruptEnables_r;
				mode_cmd_pkg::CFG_OFS: regRdata <= terminalConfiguration_r;
				mode_cmd_pkg::BITW_A_OFS: regRdata <= bitWordA_r;
				mode_cmd_pkg::BITW_B_OFS: regRdata <= bitWordB_r;
				default: regRdata <= 16'h0000;
			endcase
		end
	end
endmodule

/* File: sim/rt_mode_command_handler_monitor.sv */
// checker for the mode command handler ports
`timescale 1ns/100ps
module rt_mode_command_handler_monitor (
	input wire logic clk,
	input wire logic nrst,
	input wire logic cmdStrobe,
	input wire mode_cmd_pkg::cmd_t cmdIn,
	input wire logic [15:0] rxData,
	input wire mode_cmd_pkg::decision_t decision,
	input wire logic decisionValid,
	input wire logic messageErrorFlag,
	input wire logic storeStrobe,
	input wire logic [15:0] storeData,
	input wire logic logStrobe,
	input wire logic [15:0] interruptInfoWord,
	input wire logic [15:0] interruptAddressWord,
	input wire logic interruptOutN
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	// subaddress all zeros or all ones marks a mode command
	wire modeSub = cmdIn.subaddr == 5'h00 || cmdIn.subaddr == 5'h1F;
	// decision, logging and storage relations
	a_mode_decision_next: assert property (cmdStrobe && modeSub |=>
		decisionValid) else $error("no decision after mode command");
	a_nonmode_no_decision: assert property (cmdStrobe && !modeSub |=>
		!decisionValid) else $error("decision for non-mode command");
	a_log_info_flag: assert property (logStrobe |->
		interruptInfoWord[0]) else $error("info word lacks access flag");
	a_log_addr_desc: assert property (logStrobe |->
		interruptAddressWord == decision.descAddr) else $error("bad log address");
	a_log_before_int: assert property ($fell(interruptOutN) |->
		$past(logStrobe, 3)) else $error("interrupt without log entry");
	a_int_after_log: assert property (logStrobe && interruptOutN |->
		##3 !interruptOutN) else $error("interrupt not asserted");
	a_low_code_status: assert property (decisionValid && decision.valid
		&& !$past(cmdIn.code[4]) && !$past(cmdIn.bcast) |->
		decision.resp == mode_cmd_pkg::RESP_STATUS) else $error("code 0-15 resp");
	a_illegal_no_data: assert property (decisionValid && decision.illegal
		|-> decision.resp inside {mode_cmd_pkg::RESP_NONE,
		mode_cmd_pkg::RESP_STATUS}) else $error("illegal command moves data");
	a_error_flag_set: assert property (decisionValid && decision.valid |->
		messageErrorFlag == decision.illegal) else $error("message error flag");
	a_bcast_tx_high: assert property (decisionValid && $past(cmdIn.tr)
		&& $past(cmdIn.code[4]) |-> !decision.bcastOk) else $error("bcast ok");
	a_bcast_tx_nolog: assert property (logStrobe |->
		!($past(cmdIn.bcast) && $past(cmdIn.tr)
		&& $past(cmdIn.code[4]))) else $error("broadcast transmit logged");
	a_store_data_word: assert property (storeStrobe |->
		storeData == $past(rxData)) else $error("stored word differs");
	c_logged: cover property (logStrobe);
	c_stored: cover property (storeStrobe);
	c_illegal: cover property (decisionValid && decision.illegal);
endmodule
bind rt_mode_command_handler rt_mode_command_handler_monitor mon_inst (.*);

/* File: sim/bc_model.sv */
// bus controller model issuing mode commands and data words
`timescale 1ns/100ps
module bc_model (
	input wire logic clk,
	output mode_cmd_pkg::cmd_t cmdIn,
	output logic cmdStrobe,
	output logic [15:0] cmdWord,
	output logic [15:0] descControl,
	output logic illegalBit,
	output logic rxDataStrobe,
	output logic [15:0] rxData
);
	// idle bus at time zero
	initial begin
		cmdStrobe = 1'b0;
		rxDataStrobe = 1'b0;
		cmdIn = '0;
		cmdWord = 16'h0000;
		descControl = 16'h0000;
		illegalBit = 1'b0;
		rxData = 16'h0000;
	end
	// one command word, then released lines show inverse
	task automatic cmd(input logic tr, input logic [4:0] sa,
		input logic [4:0] code, input logic bc, input logic il,
		input logic [15:0] dc);
		@(posedge clk);
		cmdStrobe <= 1'b1;
		cmdIn <= {tr, sa, code, bc};
		cmdWord <= {(bc ? 5'h1F : 5'h05), tr, sa, code};
		descControl <= dc;
		illegalBit <= il;
		@(posedge clk);
		cmdStrobe <= 1'b0;
		cmdIn <= ~{tr, sa, code, bc};
		cmdWord <= ~{(bc ? 5'h1F : 5'h05), tr, sa, code};
		descControl <= ~dc;
		illegalBit <= ~il;
		#1;
	endtask
	// one data word following a command
	task automatic data(input logic [15:0] d);
		@(posedge clk);
		rxDataStrobe <= 1'b1;
		rxData <= d;
		@(posedge clk);
		rxDataStrobe <= 1'b0;
		rxData <= ~d;
		#1;
	endtask
endmodule

/* File: sim/rt_mode_command_handler_tb.sv */
// self-checking bench for the mode command handler
`timescale 1ns/100ps
module rt_mode_command_handler_tb;
	typedef struct packed {
		logic uci, ill, tr;
		logic [4:0] code;
		logic ok;
		logic [1:0] resp;
	} row_t;
	// resp: 1 status, 2 status plus data, 3 receive data
	row_t rows[12] = '{'{0,0,1,5'h02,1,2'h1}, '{0,0,1,5'h13,1,2'h2},
		'{0,0,0,5'h11,1,2'h3}, '{0,0,0,5'h05,1,2'h1}, '{1,0,0,5'h05,0,2'h0},
		'{0,0,1,5'h14,1,2'h2}, '{1,0,1,5'h15,0,2'h0}, '{0,0,0,5'h10,1,2'h3},
		'{0,1,0,5'h19,1,2'h1}, '{0,0,1,5'h1C,1,2'h2}, '{0,1,1,5'h08,1,2'h1},
		'{1,1,1,5'h12,1,2'h1}};
	// broadcast cases {tr, code, allowed}
	logic [6:0] bcs[6] = '{7'h47, 7'h60, 7'h29, 7'h04, 7'h40, 7'h3F};
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic [15:0] regAddr = 16'h0000;
	logic [15:0] regWdata = 16'h0000;
	mode_cmd_pkg::cmd_t cmdIn;
	mode_cmd_pkg::decision_t decision;
	logic cmdStrobe, illegalBit, rxDataStrobe, isMode, decisionValid;
	logic messageErrorFlag, storeStrobe, logStrobe, interruptOutN;
	logic [15:0] cmdWord, descControl, rxData, regRdata, txData;
	logic [15:0] storeAddr, storeData, interruptInfoWord;
	logic [15:0] interruptAddressWord;
	int errors = 0;
	int total_checks = 0;
	rt_mode_command_handler rt_mode_command_handler_inst (.*);
	bc_model bc_model_inst (.*);
	// clock
	initial forever #50 clk = ~clk;
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk);
		regWrite <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [15:0] exp);
		@(posedge clk);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRead <= 1'b0;
		#1 check(regRdata, exp);
	endtask
	task automatic results;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// watchdog
	initial begin
		#500000;
		errors++;
		results();
	end
	// main sequence
	initial begin
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		#1 check(16'(interruptOutN), 16'h0001);
		rd(mode_cmd_pkg::CFG_OFS, 16'h0000);
		rd(mode_cmd_pkg::PEND_OFS, 16'h0000);
		rd(16'h0005, 16'h0000);
		foreach (rows[i]) begin
			wr(mode_cmd_pkg::CFG_OFS, {13'h0, rows[i].uci, 2'h0});
			bc_model_inst.cmd(rows[i].tr, {5{i[0]}}, rows[i].code, 1'b0,
				rows[i].ill, 16'h0000);
			check(16'(isMode), 16'h0001);
			check(16'(decision.valid), 16'(rows[i].ok));
			check(16'(decision.resp), 16'(rows[i].resp));
			if (rows[i].ok)
				check(16'(messageErrorFlag), 16'(rows[i].ill));
			if (rows[i].resp == 2'h3) begin
				bc_model_inst.data(16'hC35A);
				check(16'(storeStrobe), 16'h0001);
				check(storeData, 16'hC35A);
			end
		end
		wr(mode_cmd_pkg::CFG_OFS, 16'h0000);
		foreach (bcs[i]) begin
			bc_model_inst.cmd(bcs[i][6], 5'h00, bcs[i][5:1], 1'b1, 1'b0, 16'h0);
			check(16'(decision.bcastOk), 16'(bcs[i][0]));
		end
		bc_model_inst.cmd(1'b1, 5'h03, 5'h02, 1'b0, 1'b0, 16'h0000);
		check(16'(decisionValid), 16'h0000);
		check(16'(isMode), 16'h0000);
		// access interrupt, logging and clearing
		wr(mode_cmd_pkg::IEN_OFS, 16'h0001);
		rd(mode_cmd_pkg::IEN_OFS, 16'h0001);
		bc_model_inst.cmd(1'b1, 5'h00, 5'h02, 1'b0, 1'b0, 16'h8000);
		check(16'(logStrobe), 16'h0001);
		check(interruptAddressWord, mode_cmd_pkg::DESC_TX_BASE + 16'h8);
		check(interruptInfoWord, 16'h0001);
		repeat (4) @(posedge clk);
		#1 check(16'(interruptOutN), 16'h0000);
		rd(mode_cmd_pkg::PEND_OFS, 16'h0001);
		wr(mode_cmd_pkg::PEND_OFS, 16'h0001);
		rd(mode_cmd_pkg::PEND_OFS, 16'h0000);
		check(16'(interruptOutN), 16'h0001);
		bc_model_inst.cmd(1'b1, 5'h00, 5'h02, 1'b0, 1'b0, 16'h0000);
		check(16'(logStrobe), 16'h0000);
		bc_model_inst.cmd(1'b1, 5'h00, 5'h13, 1'b1, 1'b0, 16'h8000);
		check(16'(logStrobe), 16'h0000);
		// self-test word source and data storage
		wr(mode_cmd_pkg::BITW_A_OFS, 16'hA5A5);
		wr(mode_cmd_pkg::BITW_B_OFS, 16'h5A5A);
		for (int k = 0; k < 2; k++) begin
			wr(mode_cmd_pkg::CFG_OFS, k[0] ? 16'h0008 : 16'h0000);
			bc_model_inst.cmd(1'b1, 5'h00, 5'h13, 1'b0, 1'b0, 16'h0000);
			@(posedge clk);
			#1 check(txData, k[0] ? 16'h5A5A : 16'hA5A5);
			wr(mode_cmd_pkg::CFG_OFS, k[0] ? 16'h0002 : 16'h0000);
			bc_model_inst.cmd(1'b0, 5'h1F, 5'h11, 1'b0, 1'b0, 16'h1234);
			bc_model_inst.data(16'h3C3C);
			check(storeAddr, k[0] ? mode_cmd_pkg::DESC_RX_BASE + 16'h47
				: 16'h1234);
		end
		bc_model_inst.data(16'h0F0F);
		check(16'(storeStrobe), 16'h0000);
		// last command reply, then a reset in mid-run
		bc_model_inst.cmd(1'b1, 5'h00, 5'h12, 1'b0, 1'b0, 16'h0000);
		check(txData, {5'h05, 1'b0, 5'h1F, 5'h11});
		wr(mode_cmd_pkg::CFG_OFS, 16'h0006);
		rd(mode_cmd_pkg::CFG_OFS, 16'h0006);
		@(posedge clk);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		#1 check(16'(interruptOutN), 16'h0001);
		rd(mode_cmd_pkg::CFG_OFS, 16'h0000);
		results();
	end
endmodule
